// ### touch_acquisition_control.sv
// acquisition sequencing and touch screen switch control around the converter
//
// What this block does
// RQ1 - control bit 11 clear selects ratiometric touch reference
// RQ2 - ancillary and supply channels use chip reference
// RQ3 - ratiometric Y: reference across Y plates, sample X+
// RQ4 - single-ended X: excite X plates, sample Y+
// RQ5 - code 1010b runs pressure A into slot 11010b
// RQ6 - code 0010b runs pressure B into slot 10010b
// RQ7 - pressure excites Y+ and X-, samples Y-/X+
// RQ8 - no acquisition starts while inhibit is active
// RQ9 - inhibit aborts acquisition, restarts once released
// RQ10 - polarity bit set means inhibit active high
// RQ11 - polarity bit resets to zero, active low
// RQ12 - inhibit ignored in hold and first delay
// RQ13 - inhibit gating covers every converter channel
// RQ14 - outside holds pin inactive to disable monitoring
// RQ15 - single-ended mode drops excitation after acquisition
// RQ16 - ratiometric mode keeps excitation through conversion
// RQ17 - serial clock also times converter sequencing
// RQ18 - inhibit synchronised two stages, polarity applied after
`timescale 1ns/1ps
module touch_acquisition_control
  import touch_acq_pkg::*;
#(
  parameter int RESULT_W   = 12,
  parameter int ACQ_CNT    = ACQ_CYCLES,
  parameter int CONV_CNT   = CONV_CYCLES,
  parameter int DLY_UNIT   = DLY_UNIT_CYCLES
) (
  // clock (the serial clock, also the converter clock) and reset
  input  wire logic                mclk_in,
  input  wire logic                arst_n_in,
  // register port
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [ADDR_W-1:0]   reg_addr_in,
  input  wire logic [DATA_W-1:0]   reg_wdata_in,
  output logic      [DATA_W-1:0]   reg_rdata_out,
  output logic                     reg_rvalid_out,
  // lcd noise signal
  input  wire logic                acquisition_inhibit_pin_in,
  // converter core
  input  wire logic [RESULT_W-1:0] adc_result_in,
  output logic                     sample_out,
  output logic                     hold_out,
  output switch_t                  switch_out,
  // status
  output logic                     busy_out,
  output logic                     done_out
);

  initial begin
    if (RESULT_W < 1 || RESULT_W > DATA_W || ACQ_CNT < 1 || CONV_CNT < 1 ||
        DLY_UNIT < 1 || ACQ_CNT >= 2**CNT_W || CONV_CNT >= 2**CNT_W ||
        DLY_UNIT * 3 >= 2**CNT_W) begin
      $error("touch_acquisition_control: parameter out of range");
    end
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_WAIT,
    ST_ACQ,
    ST_CONV,
    ST_STORE
  } state_t;

  // switch setup for a channel; touch channels follow the reference mode
  function automatic switch_t channel_switches(input logic [3:0] chan, input logic single_end);
    switch_t s;
    s = SWITCH_IDLE;
    s.in_sel = chan;
    case (chan)
      CH_XP: begin
        // y position: y plate excited, x+ sensed
        s.yp_to_supply = 1'b1;
        s.ym_to_ground = 1'b1;
        s.in_sel       = MUX_XP;
        s.ref_sel      = single_end ? REF_INTERNAL : REF_Y_PLATES;  // [RQ1] [RQ3]
      end
      CH_YP: begin
        // x position: x plate excited, y+ sensed
        s.xp_to_supply = 1'b1;                                      // [RQ4]
        s.xm_to_ground = 1'b1;
        s.in_sel       = MUX_YP;
        s.ref_sel      = single_end ? REF_INTERNAL : REF_X_PLATES;  // [RQ1]
      end
      CH_PRESS_A, CH_PRESS_B: begin
        s.yp_to_supply = 1'b1;                                      // [RQ7]
        s.xm_to_ground = 1'b1;
        s.in_sel       = (chan == CH_PRESS_A) ? MUX_YM : MUX_XP;    // [RQ5] [RQ6]
        s.ref_sel      = single_end ? REF_INTERNAL : REF_YP_XM;     // [RQ1]
      end
      default: begin
        s.ref_sel      = REF_INTERNAL;                              // [RQ2]
      end
    endcase
    return s;
  endfunction : channel_switches

  // register state
  logic [DATA_W-1:0] ctrl1_q, ctrl1_d;
  logic [DATA_W-1:0] ctrl2_q, ctrl2_d;
  logic              rd_pend_q, rd_pend_d;
  logic              rd_res_q, rd_res_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              rvalid_q, rvalid_d;
  logic [DATA_W-1:0] ctrl_rd_q, ctrl_rd_d;
  logic [RESULT_W-1:0] res_rd_data;

  // sequencer state
  state_t            state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [3:0]        chan_q, chan_d;
  logic              single_q, single_d;
  logic              sample_q, sample_d;
  logic              hold_q, hold_d;
  switch_t           sw_q, sw_d;
  logic              done_q, done_d;
  logic              busy_q, busy_d;
  logic              store_wr;

  // inhibit synchroniser: first stage feeds only the second
  logic              inh_meta_q, inh_sync_q;
  logic              inhibit_active;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // idle pin level for the reset polarity, so no phantom inhibit after reset
      inh_meta_q <= 1'b1;
      inh_sync_q <= 1'b1;
    end else begin
      inh_meta_q <= acquisition_inhibit_pin_in;                     // [RQ18]
      inh_sync_q <= inh_meta_q;
    end
  end

  // polarity applied after synchronisation so a polarity write never glitches the flops
  assign inhibit_active = ctrl2_q[POL_BIT] ? inh_sync_q : ~inh_sync_q;  // [RQ10] [RQ18]

  // register port: writes, and a read pipeline of fixed two-cycle latency
  always_comb begin
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    rd_pend_d = 1'b0;
    rd_res_d  = 1'b0;
    ctrl_rd_d = '0;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    if (reg_wr_in) begin
      if (reg_addr_in == ADDR_CTRL1) begin
        ctrl1_d = reg_wdata_in;
      end else if (reg_addr_in == ADDR_CTRL2) begin
        ctrl2_d = reg_wdata_in;
      end
    end
    if (reg_rd_in) begin
      rd_pend_d = 1'b1;
      if (reg_addr_in[RESULT_SEL_BIT]) begin
        rd_res_d = 1'b1;
      end else if (reg_addr_in == ADDR_CTRL1) begin
        ctrl_rd_d = ctrl1_q;
      end else if (reg_addr_in == ADDR_CTRL2) begin
        ctrl_rd_d = ctrl2_q;
      end else begin
        ctrl_rd_d = '0;
      end
    end
    if (rd_pend_q) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_res_q ? DATA_W'(res_rd_data) : ctrl_rd_q;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl1_q   <= CTRL1_RESET;
      ctrl2_q   <= CTRL2_RESET;                                     // [RQ11]
      rd_pend_q <= 1'b0;
      rd_res_q  <= 1'b0;
      ctrl_rd_q <= '0;
      rdata_q   <= '0;
      rvalid_q  <= 1'b0;
    end else begin
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      rd_pend_q <= rd_pend_d;
      rd_res_q  <= rd_res_d;
      ctrl_rd_q <= ctrl_rd_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // conversion sequencer; a first-word write starts a conversion when idle
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    chan_d   = chan_q;
    single_d = single_q;
    sample_d = 1'b0;
    hold_d   = 1'b0;
    sw_d     = sw_q;
    done_d   = 1'b0;
    store_wr = 1'b0;
    case (state_q)
      ST_IDLE: begin
        sw_d = SWITCH_IDLE;
        if (reg_wr_in && reg_addr_in == ADDR_CTRL1) begin
          chan_d   = reg_wdata_in[CHAN_LSB +: CHAN_W];
          single_d = reg_wdata_in[REF_MODE_BIT];                    // [RQ1]
          sw_d     = channel_switches(reg_wdata_in[CHAN_LSB +: CHAN_W],
                                      reg_wdata_in[REF_MODE_BIT]);
          cnt_d    = CNT_W'(DLY_UNIT * int'(ctrl2_q[DLY_LSB +: DLY_W]));
          state_d  = ST_DELAY;
        end
      end
      ST_DELAY: begin
        // settling time: inhibit not looked at here
        if (cnt_q == '0) begin                                      // [RQ12]
          state_d = ST_WAIT;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_WAIT: begin
        // gate is channel independent, so every input is covered
        if (!inhibit_active) begin                                  // [RQ8] [RQ13]
          cnt_d    = CNT_W'(ACQ_CNT - 1);
          sample_d = 1'b1;
          state_d  = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (inhibit_active) begin
          state_d = ST_WAIT;                                        // [RQ9]
        end else if (cnt_q == '0) begin
          cnt_d   = CNT_W'(CONV_CNT - 1);
          hold_d  = 1'b1;
          state_d = ST_CONV;
          if (single_q) begin
            sw_d.yp_to_supply = 1'b0;                               // [RQ15]
            sw_d.xp_to_supply = 1'b0;
            sw_d.ym_to_ground = 1'b0;
            sw_d.xm_to_ground = 1'b0;
          end
        end else begin
          cnt_d    = cnt_q - 1'b1;
          sample_d = 1'b1;
        end
      end
      ST_CONV: begin
        // hold phase: inhibit ignored, excitation kept in ratiometric mode
        if (cnt_q == '0) begin                                      // [RQ12] [RQ16]
          state_d = ST_STORE;
        end else begin
          cnt_d  = cnt_q - 1'b1;
          hold_d = 1'b1;
        end
      end
      ST_STORE: begin
        store_wr = 1'b1;                                            // [RQ5] [RQ6]
        done_d   = 1'b1;
        sw_d     = SWITCH_IDLE;
        state_d  = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  // all sequencing runs on the serial clock
  always_ff @(posedge mclk_in or negedge arst_n_in) begin            // [RQ17]
    if (!arst_n_in) begin
      state_q  <= ST_IDLE;
      cnt_q    <= '0;
      chan_q   <= '0;
      single_q <= 1'b0;
      sample_q <= 1'b0;
      hold_q   <= 1'b0;
      sw_q     <= SWITCH_IDLE;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      chan_q   <= chan_d;
      single_q <= single_d;
      sample_q <= sample_d;
      hold_q   <= hold_d;
      sw_q     <= sw_d;
      done_q   <= done_d;
      busy_q   <= busy_d;
    end
  end

  // result slot index is the channel code; read address is 1 followed by it
  result_store #(
    .WIDTH (RESULT_W),
    .DEPTH (16)
  ) u_results (
    .mclk_in     (mclk_in),
    .arst_n_in   (arst_n_in),
    .wr_in       (store_wr),
    .wr_addr_in  (chan_q),
    .wr_data_in  (adc_result_in),
    .rd_addr_in  (reg_addr_in[3:0]),
    .rd_data_out (res_rd_data)
  );

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign sample_out     = sample_q;
  assign hold_out       = hold_q;
  assign switch_out     = sw_q;
  assign busy_out       = busy_q;
  assign done_out       = done_q;

endmodule : touch_acquisition_control

// ### touch_acq_pkg.sv
// shared constants and carrier types for the touch acquisition control block
package touch_acq_pkg;

  // register port addressing
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 12;
  localparam logic [4:0]  ADDR_CTRL1     = 5'h01;
  localparam logic [4:0]  ADDR_CTRL2     = 5'h02;
  localparam int          RESULT_SEL_BIT = 4;

  // first control word layout
  localparam int          REF_MODE_BIT   = 11;
  localparam int          CHAN_LSB       = 7;
  localparam int          CHAN_W         = 4;
  localparam logic [11:0] CTRL1_RESET    = 12'h000;

  // second control word layout
  localparam int          POL_BIT        = 3;
  localparam int          DLY_LSB        = 0;
  localparam int          DLY_W          = 2;
  localparam logic [11:0] CTRL2_RESET    = 12'h000;

  // channel codes
  localparam logic [3:0]  CH_XP          = 4'h0;
  localparam logic [3:0]  CH_YP          = 4'h1;
  localparam logic [3:0]  CH_PRESS_B     = 4'h2;
  localparam logic [3:0]  CH_ANC_ONE     = 4'h3;
  localparam logic [3:0]  CH_ANC_TWO     = 4'h4;
  localparam logic [3:0]  CH_ANC_THREE   = 4'h5;
  localparam logic [3:0]  CH_SUPPLY_ONE  = 4'h6;
  localparam logic [3:0]  CH_SUPPLY_TWO  = 4'h7;
  localparam logic [3:0]  CH_THERM_ONE   = 4'h8;
  localparam logic [3:0]  CH_THERM_TWO   = 4'h9;
  localparam logic [3:0]  CH_PRESS_A     = 4'ha;

  // converter input selection (matches the analog mux wiring)
  localparam logic [3:0]  MUX_XP         = 4'h0;
  localparam logic [3:0]  MUX_YP         = 4'h1;
  localparam logic [3:0]  MUX_YM         = 4'h2;

  // timing at 125 MHz
  localparam int          CLK_PERIOD_PS  = 8000;
  localparam int          ACQ_TIME_NS    = 1500;
  localparam int          ACQ_CYCLES     = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CONV_CYCLES    = 13;
  localparam int          DLY_UNIT_US    = 2;
  localparam int          DLY_UNIT_CYCLES =
    (DLY_UNIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CNT_W          = 16;

  typedef enum logic [1:0] {
    REF_INTERNAL,
    REF_Y_PLATES,
    REF_X_PLATES,
    REF_YP_XM
  } ref_sel_t;

  typedef struct packed {
    logic     yp_to_supply;
    logic     xp_to_supply;
    logic     ym_to_ground;
    logic     xm_to_ground;
    logic [3:0] in_sel;
    ref_sel_t ref_sel;
  } switch_t;

  localparam switch_t SWITCH_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 4'h0, REF_INTERNAL};

endpackage : touch_acq_pkg

// ### result_store.sv
// result slot memory with registered read data
`timescale 1ns/1ps
module result_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     arst_n_in,
  // write side
  input  wire logic                     wr_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  initial begin
    if (WIDTH < 1 || DEPTH < 2) begin
      $error("result_store: bad geometry");
    end
  end

  // storage carries no reset; a slot reads unknown until its first write
  always_ff @(posedge mclk_in) begin
    if (wr_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule : result_store

// ### touch_acq_properties.sv
// port-level checks for the touch acquisition control block
`timescale 1ns/1ps
module touch_acq_properties
  import touch_acq_pkg::*;
#(
  parameter int ACQ_CNT  = ACQ_CYCLES,
  parameter int CONV_CNT = CONV_CYCLES
) (
  // clock and reset
  input wire logic              mclk_in,
  input wire logic              arst_n_in,
  // register port
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_rvalid_out,
  // converter side
  input wire logic              acquisition_inhibit_pin_in,
  input wire logic              sample_out,
  input wire logic              hold_out,
  input wire switch_t           switch_out
);
  logic        pol_q, pol_d, inh, excite;
  logic [15:0] samp_q, samp_d, hold_q, hold_d;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // polarity mirrored from writes so the pin is judged as the block judges it
  always_comb begin
    pol_d = pol_q;
    if (reg_wr_in && reg_addr_in == ADDR_CTRL2) begin
      pol_d = reg_wdata_in[POL_BIT];
    end
    samp_d = sample_out ? samp_q + 16'h1 : 16'h0;
    hold_d = hold_out ? hold_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pol_q  <= 1'b0;
      samp_q <= 16'h0;
      hold_q <= 16'h0;
    end else begin
      pol_q  <= pol_d;
      samp_q <= samp_d;
      hold_q <= hold_d;
    end
  end
  assign inh    = (acquisition_inhibit_pin_in == pol_q);
  assign excite = |{switch_out.yp_to_supply, switch_out.xp_to_supply,
                    switch_out.ym_to_ground, switch_out.xm_to_ground};

  sequence acq_done_s;
    $fell(sample_out) ##0 hold_out;
  endsequence
  sequence conv_done_s;
    $fell(hold_out);
  endsequence

  chk_acq_full: assert property (acq_done_s |-> samp_q == 16'(ACQ_CNT))
    else $error("acquisition phase length wrong");
  chk_hold_len: assert property (conv_done_s |-> hold_q == 16'(CONV_CNT))
    else $error("conversion phase length wrong");
  chk_inhibit_stop: assert property (inh [*5] |-> !sample_out)
    else $error("acquiring while inhibit active");
  chk_ratio_excite: assert property (hold_out && switch_out.ref_sel != REF_INTERNAL |-> excite)
    else $error("ratiometric excitation dropped in hold");
  chk_single_drop: assert property ($rose(hold_out) && switch_out.ref_sel == REF_INTERNAL |-> !excite)
    else $error("single-ended excitation kept in hold");
  chk_chip_ref: assert property (sample_out && switch_out.in_sel > MUX_YM |->
    switch_out.ref_sel == REF_INTERNAL && !excite)
    else $error("chip channel not on chip reference");
  chk_press_setup: assert property (sample_out && switch_out.yp_to_supply &&
    switch_out.xm_to_ground |-> !switch_out.xp_to_supply && !switch_out.ym_to_ground &&
    (switch_out.in_sel == MUX_YM || switch_out.in_sel == MUX_XP))
    else $error("pressure switch setup wrong");
  chk_sample_stable: assert property (sample_out && $past(sample_out) |-> $stable(switch_out))
    else $error("switches moved during acquisition");
  chk_read_answer: assert property (reg_rd_in |-> ##2 reg_rvalid_out)
    else $error("read answer missing");
endmodule : touch_acq_properties

bind touch_acquisition_control touch_acq_properties #(
  .ACQ_CNT (ACQ_CNT),
  .CONV_CNT(CONV_CNT)
) u_props (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rvalid_out(reg_rvalid_out),
  .acquisition_inhibit_pin_in(acquisition_inhibit_pin_in), .sample_out(sample_out),
  .hold_out(hold_out), .switch_out(switch_out)
);

// ### touch_screen_model.sv
// four-wire screen and lcd noise signal as seen from the converter pins
`timescale 1ns/1ps
module touch_screen_model
  import touch_acq_pkg::*;
(
  // converter side
  input  wire logic        mclk_in,
  input  wire logic        sample_in,
  input  wire switch_t     switch_in,
  output logic [11:0]      result_out,
  // lcd side
  input  wire logic        noise_in,
  input  wire logic        pol_in,
  output logic             inhibit_pin_out
);
  switch_t seen_q;
  // outside the noisy phase the pin rests at the inactive level
  assign inhibit_pin_out = noise_in ? pol_in : ~pol_in;
  // the held voltage is whatever the plates showed while tracking
  always_ff @(posedge mclk_in) begin
    if (sample_in) begin
      seen_q <= switch_in;
    end
  end
  assign result_out = {2'h0, seen_q};
endmodule : touch_screen_model

// ### touch_acquisition_control_tb_top.sv
// self-checking bench for the touch acquisition control block
`timescale 1ns/1ps
module touch_acquisition_control_tb_top
  import touch_acq_pkg::*;
  ;
  logic              mclk_in, arst_n_in, reg_wr_in, reg_rd_in, noise, inhibit_polarity, seen, se;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, rd;
  logic              reg_rvalid_out, pin, sample_out, hold_out, busy_out, done_out;
  logic [11:0]       adc;
  logic [3:0]        ch;
  logic [1:0]        dly;
  switch_t           switch_out;
  int                num_errors, cmp_count, cycles;

  // short counts keep the run brief
  touch_acquisition_control #(.ACQ_CNT(4), .CONV_CNT(3), .DLY_UNIT(2)) u_dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .acquisition_inhibit_pin_in(pin), .adc_result_in(adc),
    .sample_out(sample_out), .hold_out(hold_out), .switch_out(switch_out),
    .busy_out(busy_out), .done_out(done_out));
  touch_screen_model u_screen (.mclk_in(mclk_in), .sample_in(sample_out),
    .switch_in(switch_out), .result_out(adc), .noise_in(noise), .pol_in(inhibit_polarity),
    .inhibit_pin_out(pin));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [4:0] a, input logic [11:0] d);
    @(posedge mclk_in);
    #1 reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(posedge mclk_in);
    #1 reg_wr_in = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, output logic [11:0] d);
    @(posedge mclk_in);
    #1 reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(posedge mclk_in);
    #1 reg_rd_in = 1'b0;
    @(posedge mclk_in);
    #1 d = reg_rvalid_out ? reg_rdata_out : 12'hfff;
  endtask : reg_read

  // 0 waits for done, 1 for sample, 2 for hold
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while ((sel == 0 ? done_out : sel == 1 ? sample_out : hold_out) !== 1'b1 && n < 400) begin
      @(posedge mclk_in);
      #1 n++;
    end
  endtask : wait_for

  function automatic switch_t exp_sw(input logic [3:0] c, input logic s);
    ref_sel_t r;
    r = s ? REF_INTERNAL : REF_YP_XM;
    case (c)
      CH_XP:      return '{1'b1, 1'b0, 1'b1, 1'b0, MUX_XP, s ? REF_INTERNAL : REF_Y_PLATES};
      CH_YP:      return '{1'b0, 1'b1, 1'b0, 1'b1, MUX_YP, s ? REF_INTERNAL : REF_X_PLATES};
      CH_PRESS_A: return '{1'b1, 1'b0, 1'b0, 1'b1, MUX_YM, r};
      CH_PRESS_B: return '{1'b1, 1'b0, 1'b0, 1'b1, MUX_XP, r};
      default:    return '{1'b0, 1'b0, 1'b0, 1'b0, c, REF_INTERNAL};
    endcase
  endfunction : exp_sw

  task automatic conv(input logic [3:0] c, input logic s, input logic [4:0] slot);
    reg_write(ADDR_CTRL1, {s, c, 7'h00});
    check(12'h001, {11'h0, busy_out});
    wait_for(0);
    check(12'h001, {11'h0, done_out});
    check(12'h000, {11'h0, busy_out});
    reg_read(slot, rd);
    check({2'h0, exp_sw(c, s)}, rd);
  endtask : conv

  initial begin
    {reg_wr_in, reg_rd_in, noise, inhibit_polarity, arst_n_in} = '0;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    {num_errors, cmp_count, cycles} = '0;
    void'($urandom(32'hea417a23));
    repeat (8) @(posedge mclk_in);
    #1 arst_n_in = 1'b1;
    reg_read(ADDR_CTRL1, rd);
    check(CTRL1_RESET, rd);
    reg_read(ADDR_CTRL2, rd);
    check(CTRL2_RESET, rd);
    reg_read(5'h03, rd);
    check(12'h000, rd);
    $display("test reset_values done");
    for (int i = 0; i < 22; i++) begin
      conv(4'(i % 11), i >= 11, {1'b1, 4'(i % 11)});
    end
    conv(CH_PRESS_A, 1'b0, 5'h1a);
    conv(CH_PRESS_B, 1'b1, 5'h12);
    $display("test channel_sweep done");
    // polarity still zero, so a low pin must hold off sampling
    noise = 1'b1;
    seen = 1'b0;
    reg_write(ADDR_CTRL1, {1'b0, CH_ANC_ONE, 7'h00});
    repeat (40) begin
      @(posedge mclk_in);
      #1 seen |= sample_out;
    end
    check(12'h000, {11'h0, seen});
    noise = 1'b0;
    wait_for(0);
    check(12'h001, {11'h0, done_out});
    $display("test inhibit_blocks done");
    reg_write(ADDR_CTRL2, 12'h008);
    inhibit_polarity = 1'b1;
    reg_read(ADDR_CTRL2, rd);
    check(12'h008, rd);
    reg_write(ADDR_CTRL1, {1'b0, CH_YP, 7'h00});
    wait_for(1);
    noise = 1'b1;
    seen = 1'b0;
    // without the abort the hold phase would start inside this window
    repeat (6) begin
      @(posedge mclk_in);
      #1 seen |= hold_out;
    end
    check(12'h000, {11'h0, seen});
    check(12'h000, {11'h0, sample_out});
    noise = 1'b0;
    wait_for(0);
    reg_read({1'b1, CH_YP}, rd);
    check({2'h0, exp_sw(CH_YP, 1'b0)}, rd);
    reg_write(ADDR_CTRL1, {1'b1, CH_PRESS_A, 7'h00});
    wait_for(2);
    noise = 1'b1;
    wait_for(0);
    check(12'h001, {11'h0, done_out});
    noise = 1'b0;
    $display("test abort_and_ignore done");
    repeat (16) begin
      ch = 4'($urandom_range(10, 0));
      se = 1'($urandom);
      dly = 2'($urandom);
      reg_write(ADDR_CTRL2, {8'h00, 2'b10, dly});
      conv(ch, se, {1'b1, ch});
    end
    $display("test random_mix done");
    summarize();
  end
endmodule : touch_acquisition_control_tb_top
